//--- ddsc_pkg.sv
// constants and types shared by the sweep, keying and burst control block
package ddsc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned REG_AW          = 8;
  localparam int unsigned REG_DW          = 32;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_START       = 8'h04;
  localparam logic [7:0]  OFS_STOP        = 8'h08;
  localparam logic [7:0]  OFS_SWEEP_TIME  = 8'h0C;
  localparam logic [7:0]  OFS_HOP         = 8'h10;
  localparam logic [7:0]  OFS_FSK_RATE    = 8'h14;
  localparam logic [7:0]  OFS_CARRIER     = 8'h18;
  localparam logic [7:0]  OFS_BURST_COUNT = 8'h1C;
  localparam logic [7:0]  OFS_BURST_RATE  = 8'h20;
  localparam logic [7:0]  OFS_BURST_PHASE = 8'h24;
  localparam logic [7:0]  OFS_CMD         = 8'h28;
  localparam logic [7:0]  OFS_STATUS      = 8'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CTRL_W          = 8;
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_LOG        = 2;
  localparam int unsigned CTRL_SW_TRIG    = 3;
  localparam int unsigned CTRL_FSK_EXT    = 4;
  localparam int unsigned CTRL_GATED      = 5;
  localparam int unsigned CTRL_BURST_EXT  = 6;
  localparam int unsigned CTRL_LIM_WAVE   = 7;
  localparam int unsigned CMD_TRIG        = 0;
  localparam int unsigned ST_BUSY         = 0;
  localparam int unsigned ST_SWEEP        = 1;
  localparam int unsigned ST_BURST        = 2;
  localparam int unsigned ST_HOP          = 3;
  localparam int unsigned ST_DOWN         = 4;
  localparam int unsigned ST_COUNT_LSB    = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  RST_CTRL        = 8'h00;
  localparam logic [31:0] RST_FREQ        = 32'h0000_0000;
  localparam logic [31:0] RST_SWEEP_TIME  = 32'h0000_0100;
  localparam logic [31:0] RST_FSK_RATE    = 32'h0000_1000;
  localparam logic [31:0] RST_BURST_RATE  = 32'h0001_0000;
  localparam logic [11:0] RST_BURST_COUNT = 12'h001;
  localparam logic [11:0] RST_BURST_PHASE = 12'h000;

  // ****************************************
  // modulation memory and timing
  // ****************************************
  localparam int unsigned MOD_AW          = 12;
  localparam int unsigned MOD_DW          = 12;
  localparam int unsigned CNT_W           = 12;
  localparam logic [11:0] MOD_LAST        = 12'hFFF;
  localparam logic [12:0] MOD_MID         = 13'h0800;
  localparam logic [15:0] EXP_SEED        = 16'h0015;
  localparam int unsigned EXP_SHIFT       = 9;
  localparam longint      CLK_HZ          = 125_000_000;
  localparam longint      MHZ_HZ          = 1_000_000;
  localparam logic [31:0] TW_PER_MHZ      =
    32'((64'd1 << 32) * MHZ_HZ / CLK_HZ);
  localparam int unsigned MIN_COUNT_MAX   = 5;

  typedef enum logic [1:0]
  {
    DDSC_MODE_OFF   = 2'b00,
    DDSC_MODE_SWEEP = 2'b01,
    DDSC_MODE_FSK   = 2'b10,
    DDSC_MODE_BURST = 2'b11
  } ddsc_mode_t;

  typedef enum logic [1:0]
  {
    DDSC_SHAPE_RAMP = 2'b00,
    DDSC_SHAPE_EXP  = 2'b01,
    DDSC_SHAPE_GATE = 2'b10
  } ddsc_shape_t;
endpackage

//--- ddsc_fill_if.sv
// link between the control core and the modulation memory fill engine
`timescale 1ns/1ps
`default_nettype none
interface ddsc_fill_if;
  import ddsc_pkg::*;
  logic                start;
  ddsc_shape_t         shape;
  logic                down;
  logic [MOD_AW-1:0]   gate_len;
  logic                busy;
  logic                we;
  logic [MOD_AW-1:0]   waddr;
  logic [MOD_DW-1:0]   wdata;

  modport ctl (output start, shape, down, gate_len,
               input busy, we, waddr, wdata);
  modport eng (input start, shape, down, gate_len,
               output busy, we, waddr, wdata);
endinterface
`default_nettype wire

//--- ddsc_fill.sv
// engine that recomputes the modulation waveform into modulation memory
`timescale 1ns/1ps
`default_nettype none
module ddsc_fill
  (
  input  wire logic   core_clk,
  input  wire logic   srst,
  ddsc_fill_if.eng    f
  );
  import ddsc_pkg::*;

  logic              busy_q;
  logic [MOD_AW-1:0] idx;
  logic [23:0]       expv;
  logic [MOD_DW-1:0] shape_u;

  // ****************************************
  // walk every point once per request
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    // eight fraction bits let the small seed grow under the shift
    if (srst)
    begin
      busy_q <= 1'b0;
      idx    <= '0;
      expv   <= {EXP_SEED, 8'h00};
    end
    else if (f.start)
    begin
      busy_q <= 1'b1;
      idx    <= '0;
      expv   <= {EXP_SEED, 8'h00};
    end
    else if (busy_q)
    begin
      idx  <= idx + 1'b1;
      // geometric growth per point approximates an exponential curve
      expv <= expv + (expv >> EXP_SHIFT);
      if (idx == MOD_LAST)
        busy_q <= 1'b0;
    end
  end

  always_comb
  begin
    case (f.shape)
      DDSC_SHAPE_RAMP: shape_u = idx;
      DDSC_SHAPE_EXP:  shape_u = expv[23:12];
      default:         shape_u = '0;
    endcase
  end

  assign f.busy  = busy_q;
  assign f.we    = busy_q;
  assign f.waddr = idx;
  // falling shape for a downward sweep; burst gate is direction free
  assign f.wdata = (f.shape == DDSC_SHAPE_GATE) ?
                   ((idx < f.gate_len) ? {MOD_DW{1'b1}} : '0) :
                   (f.down ? ~shape_u : shape_u);

  a_fill_walk:
    assert property (@(posedge core_clk) disable iff (srst)
      $fell(busy_q) |-> $past(idx) == MOD_LAST)
      else $error("fill ended before the last point");

  a_ramp_dir:
    assert property (@(posedge core_clk) disable iff (srst)
      f.we && f.shape == DDSC_SHAPE_RAMP && f.down && !f.start
      |-> f.wdata == MOD_LAST - f.waddr)
      else $error("downward ramp is not falling");

  a_exp_rise:
    assert property (@(posedge core_clk) disable iff (srst)
      f.we && $past(f.we) && idx != '0 && !f.start && !$past(f.start)
      && f.shape == DDSC_SHAPE_EXP && !f.down && $stable(f.shape)
      |-> f.wdata >= $past(f.wdata))
      else $error("exponential shape not monotonic");
endmodule
`default_nettype wire

//--- ddsc_core.sv
// sweep, frequency keying and burst control core for the synthesiser
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// ****************************************
module ddsc_core
  #(parameter int unsigned WAVE_AW = 12)
  (
  input  wire logic                           core_clk,
  input  wire logic                           srst,
  input  wire logic [ddsc_pkg::REG_AW-1:0]    reg_addr,
  input  wire logic [ddsc_pkg::REG_DW-1:0]    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [ddsc_pkg::REG_DW-1:0]    reg_rdata,
  input  wire logic                           ext_trig_pin,
  input  wire logic                           single_btn_pin,
  input  wire logic                           fsk_pin,
  input  wire logic                           gate_pin,
  output logic      [WAVE_AW-1:0]             wave_addr,
  output logic      [31:0]                    freq_word,
  output logic                                burst_on,
  output logic                                dac_zero
  );
  import ddsc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [CTRL_W-1:0]  ctrl;
  logic [31:0]        start_f;
  logic [31:0]        stop_f;
  logic [31:0]        sweep_time;
  logic [31:0]        hop_f;
  logic [31:0]        fsk_rate;
  logic [31:0]        carrier_f;
  logic [CNT_W-1:0]   burst_count;
  logic [31:0]        burst_rate;
  logic [WAVE_AW-1:0] burst_phase;
  ddsc_mode_t         mode;
  logic               gated;
  logic [2:0]         pin_meta;
  logic [2:0]         pin_sync;
  logic [2:0]         pin_prev;
  logic               ext_edge;
  logic               btn_edge;
  logic               cmd_trig;
  logic               trig_any;
  logic               fill_go;
  logic               down;
  logic [32:0]        ends_sum;
  logic [31:0]        centre;
  logic [31:0]        span;
  logic [32:0]        mag;
  logic [MOD_DW-1:0]  mod_ram [0:(1 << MOD_AW)-1];
  logic [MOD_DW-1:0]  mod_val;
  logic [MOD_AW-1:0]  mod_idx;
  logic [31:0]        pt_cnt;
  logic               sweep_run;
  logic signed [12:0] mod_sgn;
  logic signed [45:0] sw_prod;
  logic               hop;
  logic [31:0]        fsk_cnt;
  logic [CNT_W-1:0]   min_cnt;
  logic [CNT_W-1:0]   eff_count;
  logic [31:0]        brate_cnt;
  logic               burst_go;
  logic               burst_run;
  logic [CNT_W-1:0]   cycles;
  logic [31:0]        prog;
  logic [32:0]        prog_sum;
  logic               burst_stop;
  logic [31:0]        phase;
  logic [31:0]        start_phase;
  logic [31:0]        next_freq;

  ddsc_fill_if fc ();

  ddsc_fill u_fill
  (
    .core_clk (core_clk),
    .srst     (srst),
    .f        (fc)
  );

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl        <= RST_CTRL;
      start_f     <= RST_FREQ;
      stop_f      <= RST_FREQ;
      sweep_time  <= RST_SWEEP_TIME;
      hop_f       <= RST_FREQ;
      fsk_rate    <= RST_FSK_RATE;
      carrier_f   <= RST_FREQ;
      burst_count <= RST_BURST_COUNT;
      burst_rate  <= RST_BURST_RATE;
      burst_phase <= WAVE_AW'(RST_BURST_PHASE);
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL:        ctrl        <= reg_wdata[CTRL_W-1:0];
        OFS_START:       start_f     <= reg_wdata;
        OFS_STOP:        stop_f      <= reg_wdata;
        OFS_SWEEP_TIME:  sweep_time  <= reg_wdata;
        OFS_HOP:         hop_f       <= reg_wdata;
        OFS_FSK_RATE:    fsk_rate    <= reg_wdata;
        OFS_CARRIER:     carrier_f   <= reg_wdata;
        OFS_BURST_COUNT: burst_count <= reg_wdata[CNT_W-1:0];
        OFS_BURST_RATE:  burst_rate  <= reg_wdata;
        OFS_BURST_PHASE: burst_phase <= reg_wdata[WAVE_AW-1:0];
        default: ;
      endcase
    end
  end

  assign mode  = ddsc_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign gated = (mode == DDSC_MODE_BURST) && ctrl[CTRL_GATED];

  // a write to any setting except hop or keying rate restarts the fill even if one is under way
  always_ff @(posedge core_clk)
  begin
    if (srst)
      fill_go <= 1'b0;
    else
      fill_go <= reg_wr && (reg_addr == OFS_CTRL || reg_addr == OFS_START
                 || reg_addr == OFS_STOP || reg_addr == OFS_SWEEP_TIME
                 || reg_addr == OFS_CARRIER
                 || reg_addr == OFS_BURST_COUNT
                 || reg_addr == OFS_BURST_RATE
                 || reg_addr == OFS_BURST_PHASE);
  end

  assign fc.start    = fill_go;
  assign fc.shape    = (mode == DDSC_MODE_BURST) ? DDSC_SHAPE_GATE :
                       (ctrl[CTRL_LOG] ? DDSC_SHAPE_EXP :
                        DDSC_SHAPE_RAMP);
  assign fc.down     = down;
  assign fc.gate_len = eff_count;

  always_ff @(posedge core_clk)
  begin
    if (fc.we)
      mod_ram[fc.waddr] <= fc.wdata;
  end

  // ****************************************
  // input synchronisers and trigger edges
  // ****************************************
  // gate pin is left out: it acts on the converter without a clock
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end
        else
        begin
          pin_meta[gi] <= (gi == 0) ? ext_trig_pin :
                          (gi == 1) ? single_btn_pin : fsk_pin;
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
    end
  endgenerate

  assign ext_edge = pin_sync[0] && !pin_prev[0];
  assign btn_edge = pin_sync[1] && !pin_prev[1];

  always_ff @(posedge core_clk)
  begin
    if (srst)
      cmd_trig <= 1'b0;
    else
      cmd_trig <= reg_wr && (reg_addr == OFS_CMD) && reg_wdata[CMD_TRIG];
  end

  assign trig_any = ext_edge || btn_edge || cmd_trig;

  // ****************************************
  // sweep
  // ****************************************
  assign down     = stop_f < start_f;
  assign ends_sum = {1'b0, start_f} + {1'b0, stop_f};
  assign centre   = ends_sum[32:1];
  assign span     = down ? (start_f - stop_f) : (stop_f - start_f);
  assign mag      = {2'b00, span[31:1]};

  // 4096 points per period, each held sweep_time cycles
  always_ff @(posedge core_clk)
  begin
    if (srst || mode != DDSC_MODE_SWEEP || fc.busy)
    begin
      sweep_run <= 1'b0;
      mod_idx   <= '0;
      pt_cnt    <= '0;
    end
    else if (!sweep_run)
    begin
      if (!ctrl[CTRL_SW_TRIG] || trig_any)
        sweep_run <= 1'b1;
    end
    else if (pt_cnt + 32'h1 >= sweep_time)
    begin
      pt_cnt  <= '0;
      mod_idx <= mod_idx + 1'b1;
      if (mod_idx == MOD_LAST)
        sweep_run <= !ctrl[CTRL_SW_TRIG];
    end
    else
      pt_cnt <= pt_cnt + 32'h1;
  end

  always_ff @(posedge core_clk)
  begin
    mod_val <= mod_ram[mod_idx];
  end

  assign mod_sgn = $signed({1'b0, mod_val}) - $signed(MOD_MID);
  assign sw_prod = $signed(mag) * mod_sgn;

  // ****************************************
  // frequency keying
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hop     <= 1'b0;
      fsk_cnt <= '0;
    end
    else if (ctrl[CTRL_FSK_EXT])
    begin
      hop     <= pin_sync[2];
      fsk_cnt <= '0;
    end
    else if (fsk_cnt + 32'h1 >= fsk_rate)
    begin
      hop     <= !hop;
      fsk_cnt <= '0;
    end
    else
      fsk_cnt <= fsk_cnt + 32'h1;
  end

  // ****************************************
  // burst
  // ****************************************
  always_comb
  begin
    min_cnt = CNT_W'(1);
    for (int k = 1; k < MIN_COUNT_MAX; k++)
    begin
      if ({32'h0, carrier_f} > 64'(TW_PER_MHZ) * 64'(k))
        min_cnt = CNT_W'(k + 1);
    end
  end

  assign eff_count = (ctrl[CTRL_LIM_WAVE] && burst_count < min_cnt) ?
                     min_cnt : burst_count;

  always_ff @(posedge core_clk)
  begin
    if (srst || mode != DDSC_MODE_BURST || gated)
      brate_cnt <= '0;
    else if (brate_cnt + 32'h1 >= burst_rate)
      brate_cnt <= '0;
    else
      brate_cnt <= brate_cnt + 32'h1;
  end

  assign burst_go = ctrl[CTRL_BURST_EXT] ? ext_edge :
                    (brate_cnt + 32'h1 >= burst_rate);
  assign prog_sum   = {1'b0, prog} + {1'b0, freq_word};
  assign burst_stop = burst_run && prog_sum[32] &&
                      (cycles + 1'b1 == eff_count);

  always_ff @(posedge core_clk)
  begin
    if (srst || mode != DDSC_MODE_BURST || gated)
    begin
      burst_run <= 1'b0;
      cycles    <= '0;
      prog      <= '0;
    end
    else if (!burst_run)
    begin
      cycles <= '0;
      prog   <= '0;
      if (burst_go)
        burst_run <= 1'b1;
    end
    else
    begin
      prog <= prog_sum[31:0];
      if (burst_stop)
        burst_run <= 1'b0;
      else if (prog_sum[32])
        cycles <= cycles + 1'b1;
    end
  end

  // phase zero is waveform memory entry zero
  assign start_phase = {burst_phase, {(32 - WAVE_AW){1'b0}}};

  // ****************************************
  // carrier addressing and outputs
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
      phase <= '0;
    else if (mode == DDSC_MODE_BURST && !gated && (!burst_run || burst_stop))
      phase <= start_phase;
    else
      phase <= phase + freq_word;
  end

  always_comb
  begin
    case (mode)
      DDSC_MODE_SWEEP: next_freq = centre + sw_prod[42:11];
      DDSC_MODE_FSK:   next_freq = hop ? hop_f : carrier_f;
      default:         next_freq = carrier_f;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      freq_word <= '0;
      wave_addr <= '0;
      burst_on  <= 1'b1;
    end
    else
    begin
      freq_word <= next_freq;
      wave_addr <= phase[31 -: WAVE_AW];
      burst_on  <= (mode != DDSC_MODE_BURST) || gated || burst_run;
    end
  end

  // deliberately unclocked so the gate acts without waiting for an edge
  assign dac_zero = gated && !gate_pin;

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (srst || !reg_rd)
      reg_rdata <= '0;
    else
    begin
      case (reg_addr)
        OFS_CTRL:        reg_rdata <= 32'(ctrl);
        OFS_START:       reg_rdata <= start_f;
        OFS_STOP:        reg_rdata <= stop_f;
        OFS_SWEEP_TIME:  reg_rdata <= sweep_time;
        OFS_HOP:         reg_rdata <= hop_f;
        OFS_FSK_RATE:    reg_rdata <= fsk_rate;
        OFS_CARRIER:     reg_rdata <= carrier_f;
        OFS_BURST_COUNT: reg_rdata <= 32'(burst_count);
        OFS_BURST_RATE:  reg_rdata <= burst_rate;
        OFS_BURST_PHASE: reg_rdata <= 32'(burst_phase);
        OFS_STATUS:
        begin
          reg_rdata                         <= '0;
          reg_rdata[ST_BUSY]                <= fc.busy;
          reg_rdata[ST_SWEEP]               <= sweep_run;
          reg_rdata[ST_BURST]               <= burst_run;
          reg_rdata[ST_HOP]                 <= hop;
          reg_rdata[ST_DOWN]                <= down;
          reg_rdata[ST_COUNT_LSB +: CNT_W]  <= eff_count;
        end
        default:         reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_start_wr;
    reg_wr && reg_addr == OFS_START;
  endsequence
  sequence s_reload;
    fill_go ##1 fc.busy;
  endsequence

  a_sweep_reload:
    assert property (s_start_wr |=> s_reload)
      else $error("start change did not reload modulation memory");

  a_burst_reload:
    assert property (reg_wr && reg_addr == OFS_CARRIER |=> s_reload)
      else $error("carrier change did not reload modulation memory");

  a_trig_single:
    assert property (ext_edge |=> !ext_edge)
      else $error("trigger edge lasted more than one cycle");

  a_sweep_once:
    assert property ($fell(sweep_run) && $stable(ctrl) && !$past(fc.busy)
      && mode == DDSC_MODE_SWEEP
      |-> mod_idx == '0 && ctrl[CTRL_SW_TRIG])
      else $error("triggered sweep did not end after one period");

  a_fsk_level:
    assert property (mode == DDSC_MODE_FSK && ctrl[CTRL_FSK_EXT]
      && $stable(ctrl) |=> hop == $past(pin_sync[2]))
      else $error("keying input level not followed");

  a_fsk_freq:
    assert property (mode == DDSC_MODE_FSK && $stable(ctrl)
      |=> freq_word == ($past(hop) ? $past(hop_f) : $past(carrier_f)))
      else $error("keyed frequency wrong");

  a_burst_count:
    assert property ($fell(burst_run) && $stable(ctrl)
      && mode == DDSC_MODE_BURST && !gated
      |-> $past(cycles) + 1'b1 == $past(eff_count))
      else $error("burst ended at wrong cycle count");

  a_burst_hold:
    assert property (mode == DDSC_MODE_BURST && !gated && !burst_run
      && $stable(ctrl) && $stable(burst_phase) |=> phase == $past(start_phase))
      else $error("idle burst not held at start phase");

  a_gate_zero:
    assert property (gated && !gate_pin |-> dac_zero)
      else $error("gate low did not zero the converter");

  a_min_count:
    assert property (ctrl[CTRL_LIM_WAVE]
      && {32'h0, carrier_f} > 64'(TW_PER_MHZ) * 64'd4
      |-> eff_count >= CNT_W'(MIN_COUNT_MAX))
      else $error("minimum burst count not applied");
endmodule
`default_nettype wire

//--- ddsc_pins.sv
// model of the external trigger, keying and gate sources
`timescale 1ns/1ps
`default_nettype none
module ddsc_pins
  (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic trig_go,
  input  wire logic fsk_lvl,
  input  wire logic gate_lvl,
  output logic      ext_trig_pin,
  output logic      fsk_pin,
  output logic      gate_pin
  );
  logic [2:0] hold;
  // trigger stays high 4 clocks, above the 2-cycle minimum per level
  always_ff @(posedge core_clk)
  begin
    if (srst)
      hold <= 3'h0;
    else if (trig_go)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign ext_trig_pin = (hold != 3'h0);
  assign fsk_pin      = fsk_lvl;
  assign gate_pin     = gate_lvl;
endmodule
`default_nettype wire

//--- ddsc_core_tb.sv
// self-checking bench for the sweep, keying and burst control core
`timescale 1ns/1ps
`default_nettype none
module ddsc_core_tb;
  import ddsc_pkg::*;
  logic        core_clk, srst, reg_wr, reg_rd, burst_on, dac_zero, btn;
  logic        trig_go, fsk_lvl, gate_lvl, ext_trig, fsk_p, gate_p;
  logic [7:0]  reg_addr;
  logic [11:0] wave_addr;
  logic [31:0] reg_wdata, reg_rdata, freq_word, rd;
  int          err_count = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  ra[6] = '{OFS_CTRL, OFS_SWEEP_TIME, OFS_FSK_RATE,
    OFS_BURST_RATE, OFS_BURST_COUNT, 8'h40};
  logic [31:0] rv[6] = '{32'h0, RST_SWEEP_TIME, RST_FSK_RATE,
    RST_BURST_RATE, {20'h0, RST_BURST_COUNT}, 32'h0};
  ddsc_core u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trig_pin(ext_trig), .single_btn_pin(btn),
    .fsk_pin(fsk_p), .gate_pin(gate_p), .wave_addr(wave_addr),
    .freq_word(freq_word), .burst_on(burst_on), .dac_zero(dac_zero));
  ddsc_pins u_pins (.core_clk(core_clk), .srst(srst), .trig_go(trig_go),
    .fsk_lvl(fsk_lvl), .gate_lvl(gate_lvl), .ext_trig_pin(ext_trig),
    .fsk_pin(fsk_p), .gate_pin(gate_p));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // fill and sweep can take thousands of clocks, so polling is bounded
  task automatic st_wait(input int b, input logic v);
    n = 0;
    do
    begin
      rd_reg(OFS_STATUS);
      n++;
    end
    while (rd[b] !== v && n < 3000);
    lim(rd[b] === v);
  endtask
  // a wait that runs out is a mismatch and ends the run at once
  task automatic lim(input logic ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    {reg_wr, reg_rd, btn, trig_go, fsk_lvl, gate_lvl} = '0;
    {reg_addr, reg_wdata} = '0;
    srst = 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    foreach (ra[i])
    begin
      rd_reg(ra[i]);
      chk(rd, rv[i]);
    end
    $display("reset test done");
    wr(OFS_CARRIER, 32'h0100_0000);
    wr(OFS_HOP, 32'h0300_0000);
    wr(OFS_FSK_RATE, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0012);
    repeat (8) @(negedge core_clk);
    chk(freq_word, 32'h0100_0000);
    @(posedge core_clk);
    fsk_lvl <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk(freq_word, 32'h0300_0000);
    rd_reg(OFS_STATUS);
    chk(rd[ST_HOP], 1'b1);
    wr(OFS_CTRL, 32'h0000_0002);
    repeat (4) @(negedge core_clk);
    rd = freq_word;
    repeat (3) @(negedge core_clk);
    chk(freq_word, (rd == 32'h0100_0000) ? 32'h0300_0000 :
      32'h0100_0000);
    $display("keying test done");
    wr(OFS_CTRL, 32'h0000_0023);
    #1 chk(dac_zero, 1'b1);
    @(posedge core_clk);
    gate_lvl <= 1'b1;
    #1 chk(dac_zero, 1'b0);
    $display("gate test done");
    wr(OFS_BURST_COUNT, 32'h0000_0002);
    wr(OFS_BURST_PHASE, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0043);
    st_wait(ST_BUSY, 1'b0);
    chk(burst_on, 1'b0);
    chk(wave_addr, 12'h100);
    @(posedge core_clk);
    trig_go <= 1'b1;
    @(posedge core_clk);
    trig_go <= 1'b0;
    n = 0;
    while (burst_on !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    lim(burst_on === 1'b1);
    n = 0;
    while (burst_on === 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    lim(burst_on !== 1'b1);
    chk((n + 8) / 256, 32'h2);
    chk(wave_addr, 12'h100);
    $display("burst test done");
    wr(OFS_CARRIER, 32'h0624_DD2F);
    wr(OFS_BURST_COUNT, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_00C3);
    rd_reg(OFS_STATUS);
    chk(rd[27:16], 12'h004);
    wr(OFS_CARRIER, 32'h0A00_0000);
    rd_reg(OFS_STATUS);
    chk(rd[27:16], 12'h005);
    wr(OFS_BURST_RATE, 32'h0000_0400);
    repeat (1100) @(negedge core_clk);
    chk(burst_on, 1'b0);
    wr(OFS_CTRL, 32'h0000_0083);
    n = 0;
    while (burst_on !== 1'b1 && n < 1100)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(burst_on, 1'b1);
    lim(burst_on === 1'b1);
    $display("min count test done");
    wr(OFS_SWEEP_TIME, 32'h0000_0001);
    wr(OFS_START, 32'h0200_0000);
    wr(OFS_STOP, 32'h0100_0000);
    wr(OFS_CTRL, 32'h0000_0009);
    st_wait(ST_BUSY, 1'b0);
    chk(freq_word, 32'h01FF_F000);
    wr(OFS_CMD, 32'h0000_0001);
    rd_reg(OFS_STATUS);
    chk(rd[ST_SWEEP], 1'b1);
    chk(rd[ST_DOWN], 1'b1);
    st_wait(ST_SWEEP, 1'b0);
    @(posedge core_clk);
    btn <= 1'b1;
    repeat (4) @(posedge core_clk);
    btn <= 1'b0;
    rd_reg(OFS_STATUS);
    chk(rd[ST_SWEEP], 1'b1);
    wr(OFS_STOP, 32'h0300_0000);
    wr(OFS_CTRL, 32'h0000_0005);
    st_wait(ST_BUSY, 1'b0);
    rd_reg(OFS_STATUS);
    chk(rd[ST_DOWN], 1'b0);
    chk(rd[ST_SWEEP], 1'b1);
    $display("sweep test done");
    print_verdict();
  end
endmodule
`default_nettype wire
